// ===== include/i2c_link_if.sv
// two-wire link between host and device, open-drain resolved here
interface i2c_link_if;
	logic scl_m_o; // host clock drive value
	logic scl_m_oe; // host drives clock
	logic sda_m_o; // host data drive value
	logic sda_m_oe; // host drives data
	logic sda_s_o; // device data drive value
	logic sda_s_oe; // device drives data
	logic scl; // resolved clock line
	logic sda; // resolved data line
	// open drain: a line is low while any driver pulls it low
	assign scl = !(scl_m_oe && !scl_m_o);
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
	modport host (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe, input scl, sda);
	modport dev (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// ===== include/i2c_port_pkg.sv
// shared constants, types and register map for the two-wire register port
package i2c_port_pkg;
	// ==========================================================
	// device register space
	localparam logic [6:0] SLAVE_ADDR = 7'h2c; // arbitrary value
	localparam int REG_N = 11; // registers 0x00..0x0a
	localparam logic [3:0] REG_LAST = 4'ha; // pointer wraps after this
	localparam logic [3:0] FSET_IDX = 4'h7; // feature_set_config
	localparam logic [3:0] WEN_IDX = 4'h8; // write_enable_gate
	localparam int UNLOCK_BIT = 7; // feature_write_unlock position
	localparam logic [7:0] REG_RST = 8'h00; // register value after reset
	localparam logic [3:0] PTR_RST = 4'h0; // pointer after reset
	localparam logic [3:0] BYTE_BITS = 4'h8; // data bits per byte
	localparam logic [3:0] ACK_SLOT = 4'h9; // ninth clock
	// ==========================================================
	// host command registers
	localparam logic [2:0] H_CTRL = 3'h0; // go + operation
	localparam logic [2:0] H_SLV = 3'h1; // target slave address
	localparam logic [2:0] H_RADR = 3'h2; // register address
	localparam logic [2:0] H_WDAT = 3'h3; // byte to write
	localparam logic [2:0] H_STAT = 3'h4; // busy, nack
	localparam logic [2:0] H_RDAT = 3'h5; // last byte read
	localparam int CTRL_GO = 0; // go bit position
	localparam int STAT_BUSY = 0; // busy bit position
	localparam int STAT_NACK = 1; // nack bit position
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 25; // 40 mhz system clock
	localparam int SCL_PERIOD_NS = 10000; // serial clock period
	localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS); // quarter bit
	// ==========================================================
	// state and command encodings
	typedef enum logic [2:0] {
		D_IDLE = 3'h0, D_RX = 3'h1, D_ACK = 3'h2, D_TX = 3'h3, D_RACK = 3'h4
	} dev_state_t;
	typedef enum logic [1:0] {
		PH_SLV = 2'h0, PH_REG = 2'h1, PH_DAT = 2'h2
	} phase_t;
	typedef enum logic [1:0] {
		M_IDLE = 2'h0, M_START = 2'h1, M_BYTE = 2'h2, M_STOP = 2'h3
	} mst_state_t;
	typedef enum logic [1:0] {
		OP_WR = 2'h0, OP_RRD = 2'h1, OP_CRD = 2'h2
	} op_t;
	typedef enum logic [2:0] {
		IT_START = 3'h0, IT_SLVW = 3'h1, IT_SLVR = 3'h2, IT_REG = 3'h3,
		IT_DAT = 3'h4, IT_RX = 3'h5, IT_STOP = 3'h6
	} item_t;
endpackage

// ===== rtl/i2c_dev_port.sv
// device end: serial slave port onto an 11-byte register space
// What this block does
// - start is data falling, clock high
// - ignore everything until a start
// - stop is data rising, clock high
// - stop after read returns to standby
// - host stops only after data released
// - release after eight bits, ack on ninth
// - ack slave byte only on address match
// - ack register address and data bytes
// - store byte at fall after bit eight
// - pointer advances after each written byte
// - pointer wraps past 0x0a to zero
// - host avoids writing above 0x08
// - random read: address, restart, read byte
// - one read bit per host clock
// - read continues on ack, stops on nack
// - pointer advances after eighth read bit
// - host ends read with nack, stop
// - current-address read from pointer
// - feature register locked after reset
// - gate bit seven unlocks feature register
// - data changes only while clock low
// - bytes travel msb first
module i2c_dev_port #(
	parameter logic [6:0] SLV_ADDR = i2c_port_pkg::SLAVE_ADDR // arbitrary
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // sync reset, low active
	input wire logic ce, // clock enable, freezes all state
	i2c_link_if.dev link, // serial link
	output logic [i2c_port_pkg::REG_N*8-1:0] regs_q // register contents
);
	// ==========================================================
	// state record
	typedef struct packed {
		i2c_port_pkg::dev_state_t st; // protocol state
		i2c_port_pkg::phase_t ph; // which byte of a frame
		logic [3:0] bitc; // clock count in byte
		logic [7:0] sh; // shift register
		logic [3:0] ptr; // register pointer
		logic rd; // read direction latched
		logic mack; // host acked last read byte
		logic sda_oe; // pulling data low
		logic pin_o; // drive value, always low
		logic scl_d; // clock one sample ago
		logic sda_d; // data one sample ago
		logic [i2c_port_pkg::REG_N-1:0][7:0] regs; // register space
	} dev_s_t;

	dev_s_t s_r;
	dev_s_t s_nxt;
	logic [1:0] lines; // synced clock and data
	logic scl; // synced clock
	logic sda; // synced data
	logic rise; // clock rising edge
	logic fall; // clock falling edge
	logic start; // start condition seen
	logic stop; // stop condition seen
	logic wr_ok; // current write passes the lock

	// ==========================================================
	// pointer step with wrap
	function automatic logic [3:0] ptr_inc(input logic [3:0] p);
		ptr_inc = (p == i2c_port_pkg::REG_LAST) ? 4'h0 : 4'(p + 4'h1);
	endfunction

	// ==========================================================
	// pin sampling
	pin_sync #(.W(2)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.d({link.scl, link.sda}),
		.q(lines)
	);

	// edges come from the synced lines against last sample
	assign scl = lines[1];
	assign sda = lines[0];
	assign rise = scl && !s_r.scl_d;
	assign fall = !scl && s_r.scl_d;
	assign start = scl && s_r.scl_d && s_r.sda_d && !sda;
	assign stop = scl && s_r.scl_d && !s_r.sda_d && sda;
	// feature register only takes writes while unlocked
	assign wr_ok = (s_r.ptr != i2c_port_pkg::FSET_IDX) ||
		s_r.regs[i2c_port_pkg::WEN_IDX][i2c_port_pkg::UNLOCK_BIT];

	// ==========================================================
	// next-state logic
	always_comb begin
		s_nxt = s_r;
		s_nxt.scl_d = scl;
		s_nxt.sda_d = sda;
		if (start) begin
			// a start aborts whatever was going on, also a restart
			s_nxt.st = i2c_port_pkg::D_RX;
			s_nxt.ph = i2c_port_pkg::PH_SLV;
			s_nxt.bitc = 4'h0;
			s_nxt.sda_oe = 1'b0;
		end else if (stop) begin
			// back to standby; pointer is kept for current reads
			s_nxt.st = i2c_port_pkg::D_IDLE;
			s_nxt.sda_oe = 1'b0;
		end else begin
			case (s_r.st)
				i2c_port_pkg::D_IDLE: begin
					// deaf until the next start
					s_nxt.sda_oe = 1'b0;
				end
				i2c_port_pkg::D_RX: begin
					if (rise) begin
						// sample on rising clock, msb arrives first
						s_nxt.sh = {s_r.sh[6:0], sda};
						s_nxt.bitc = 4'(s_r.bitc + 4'h1);
					end else if (fall && s_r.bitc == i2c_port_pkg::BYTE_BITS) begin
						// byte complete: decide on ack at this fall
						s_nxt.st = i2c_port_pkg::D_ACK;
						s_nxt.sda_oe = 1'b1;
						case (s_r.ph)
							i2c_port_pkg::PH_SLV: begin
								s_nxt.rd = s_r.sh[0];
								if (s_r.sh[7:1] != SLV_ADDR) begin
									// not ours: leave the ack slot high
									s_nxt.st = i2c_port_pkg::D_IDLE;
									s_nxt.sda_oe = 1'b0;
								end
							end
							i2c_port_pkg::PH_REG: begin
								// out-of-range address falls back to zero
								if (s_r.sh > {4'h0, i2c_port_pkg::REG_LAST}) begin
									s_nxt.ptr = 4'h0;
								end else begin
									s_nxt.ptr = s_r.sh[3:0];
								end
							end
							default: begin
								// data byte lands at this very fall
								if (wr_ok) begin
									s_nxt.regs[s_r.ptr] = s_r.sh;
								end
							end
						endcase
					end
				end
				i2c_port_pkg::D_ACK: begin
					if (fall) begin
						// end of ninth clock: let go of data
						s_nxt.sda_oe = 1'b0;
						s_nxt.bitc = 4'h0;
						s_nxt.st = i2c_port_pkg::D_RX;
						case (s_r.ph)
							i2c_port_pkg::PH_SLV: begin
								if (s_r.rd) begin
									// read begins at the pointer as it stands
									s_nxt.st = i2c_port_pkg::D_TX;
									s_nxt.sh = s_r.regs[s_r.ptr];
									s_nxt.sda_oe = !s_r.regs[s_r.ptr][7];
								end else begin
									s_nxt.ph = i2c_port_pkg::PH_REG;
								end
							end
							i2c_port_pkg::PH_REG: begin
								s_nxt.ph = i2c_port_pkg::PH_DAT;
							end
							default: begin
								// burst write moves on to next register
								s_nxt.ptr = ptr_inc(s_r.ptr);
							end
						endcase
					end
				end
				i2c_port_pkg::D_TX: begin
					if (rise) begin
						s_nxt.bitc = 4'(s_r.bitc + 4'h1);
					end else if (fall) begin
						if (s_r.bitc == i2c_port_pkg::BYTE_BITS) begin
							// eighth bit gone: release and step pointer
							s_nxt.sda_oe = 1'b0;
							s_nxt.ptr = ptr_inc(s_r.ptr);
							s_nxt.st = i2c_port_pkg::D_RACK;
						end else begin
							// next bit goes out only while clock is low
							s_nxt.sh = {s_r.sh[6:0], 1'b1};
							s_nxt.sda_oe = !s_r.sh[6];
						end
					end
				end
				i2c_port_pkg::D_RACK: begin
					if (rise) begin
						// sample host answer in the ninth clock
						s_nxt.mack = !sda;
						s_nxt.bitc = i2c_port_pkg::ACK_SLOT;
					end else if (fall && s_r.bitc == i2c_port_pkg::ACK_SLOT) begin
						if (s_r.mack) begin
							// acked: keep streaming from the pointer
							s_nxt.st = i2c_port_pkg::D_TX;
							s_nxt.bitc = 4'h0;
							s_nxt.sh = s_r.regs[s_r.ptr];
							s_nxt.sda_oe = !s_r.regs[s_r.ptr][7];
						end else begin
							// nack: go quiet, wait for stop or start
							s_nxt.st = i2c_port_pkg::D_IDLE;
						end
					end
				end
				default: begin
					s_nxt.st = i2c_port_pkg::D_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// registers; idle lines read high
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.st <= i2c_port_pkg::D_IDLE;
			s_r.ptr <= i2c_port_pkg::PTR_RST;
			s_r.regs <= {i2c_port_pkg::REG_N{i2c_port_pkg::REG_RST}};
			s_r.scl_d <= 1'b1;
			s_r.sda_d <= 1'b1;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// outputs, all straight from state
	assign link.sda_s_o = s_r.pin_o;
	assign link.sda_s_oe = s_r.sda_oe;
	assign regs_q = s_r.regs;
endmodule

// ===== rtl/i2c_host_port.sv
// host end: bus master driving single-byte register transfers
//
// Local design decision: the address-and-strobe port.
module i2c_host_port #(
	parameter int QTR = i2c_port_pkg::QTR_CYC // cycles per quarter bit
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // sync reset, low active
	input wire logic ce, // clock enable, freezes all state
	input wire logic [2:0] addr, // command register address
	input wire logic [7:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [7:0] rdata, // read data, cycle after rd
	i2c_link_if.host link // serial link
);
	// ==========================================================
	// state record
	typedef struct packed {
		i2c_port_pkg::mst_state_t st; // bit-level state
		logic [1:0] q; // quarter within bit
		logic [15:0] tick; // cycles within quarter
		i2c_port_pkg::op_t op; // current operation
		logic [2:0] step; // item index in operation
		logic [3:0] bitc; // bit in byte, 8 = ack slot
		logic [7:0] sh; // shift register
		logic rx; // byte is received
		logic [6:0] slv; // slave address
		logic [7:0] radr; // register address
		logic [7:0] wdat; // data to write
		logic [7:0] rdat; // data read
		logic busy; // transfer in progress
		logic nack; // slave failed to ack
		logic scl_oe; // pulling clock low
		logic sda_oe; // pulling data low
		logic pin_o; // drive value, always low
		logic [7:0] rd_data; // bus read answer
	} mst_s_t;

	mst_s_t s_r;
	mst_s_t s_nxt;
	logic sda; // synced data line
	logic tk; // quarter boundary

	// ==========================================================
	// item sequence of each operation
	function automatic i2c_port_pkg::item_t item_at(input i2c_port_pkg::op_t op,
		input logic [2:0] step);
		item_at = i2c_port_pkg::IT_STOP;
		case (op)
			i2c_port_pkg::OP_WR: begin
				case (step)
					3'h0: item_at = i2c_port_pkg::IT_START;
					3'h1: item_at = i2c_port_pkg::IT_SLVW;
					3'h2: item_at = i2c_port_pkg::IT_REG;
					3'h3: item_at = i2c_port_pkg::IT_DAT;
					default: item_at = i2c_port_pkg::IT_STOP;
				endcase
			end
			i2c_port_pkg::OP_RRD: begin
				// address write, restart, read byte
				case (step)
					3'h0: item_at = i2c_port_pkg::IT_START;
					3'h1: item_at = i2c_port_pkg::IT_SLVW;
					3'h2: item_at = i2c_port_pkg::IT_REG;
					3'h3: item_at = i2c_port_pkg::IT_START;
					3'h4: item_at = i2c_port_pkg::IT_SLVR;
					3'h5: item_at = i2c_port_pkg::IT_RX;
					default: item_at = i2c_port_pkg::IT_STOP;
				endcase
			end
			default: begin
				// current-address read: slave byte only
				case (step)
					3'h0: item_at = i2c_port_pkg::IT_START;
					3'h1: item_at = i2c_port_pkg::IT_SLVR;
					3'h2: item_at = i2c_port_pkg::IT_RX;
					default: item_at = i2c_port_pkg::IT_STOP;
				endcase
			end
		endcase
	endfunction

	// load the item at a step into the state
	function automatic mst_s_t enter(input mst_s_t s, input logic [2:0] step);
		mst_s_t n;
		i2c_port_pkg::item_t it;
		n = s;
		it = item_at(s.op, step);
		n.step = step;
		n.q = 2'h0;
		n.bitc = 4'h0;
		n.rx = 1'b0;
		n.st = i2c_port_pkg::M_BYTE;
		case (it)
			i2c_port_pkg::IT_START: n.st = i2c_port_pkg::M_START;
			i2c_port_pkg::IT_SLVW: n.sh = {s.slv, 1'b0};
			i2c_port_pkg::IT_SLVR: n.sh = {s.slv, 1'b1};
			i2c_port_pkg::IT_REG: n.sh = s.radr;
			i2c_port_pkg::IT_DAT: n.sh = s.wdat;
			i2c_port_pkg::IT_RX: n.rx = 1'b1;
			default: n.st = i2c_port_pkg::M_STOP;
		endcase
		return n;
	endfunction

	// ==========================================================
	// data line sampling
	pin_sync #(.W(1)) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.d(link.sda),
		.q(sda)
	);

	assign tk = (s_r.tick == 16'(QTR - 1));

	// ==========================================================
	// next-state logic
	always_comb begin
		s_nxt = s_r;
		s_nxt.rd_data = 8'h00;
		// command port, reads answer next cycle only
		if (rd) begin
			if (addr == i2c_port_pkg::H_SLV) begin
				s_nxt.rd_data = {1'b0, s_r.slv};
			end else if (addr == i2c_port_pkg::H_RADR) begin
				s_nxt.rd_data = s_r.radr;
			end else if (addr == i2c_port_pkg::H_WDAT) begin
				s_nxt.rd_data = s_r.wdat;
			end else if (addr == i2c_port_pkg::H_STAT) begin
				s_nxt.rd_data = {6'h00, s_r.nack, s_r.busy};
			end else if (addr == i2c_port_pkg::H_RDAT) begin
				s_nxt.rd_data = s_r.rdat;
			end
		end
		if (wr && !s_r.busy) begin
			// setup registers are frozen during a transfer
			if (addr == i2c_port_pkg::H_SLV) begin
				s_nxt.slv = wdata[6:0];
			end else if (addr == i2c_port_pkg::H_RADR) begin
				s_nxt.radr = wdata;
			end else if (addr == i2c_port_pkg::H_WDAT) begin
				s_nxt.wdat = wdata;
			end else if (addr == i2c_port_pkg::H_CTRL && wdata[i2c_port_pkg::CTRL_GO]) begin
				s_nxt.op = i2c_port_pkg::op_t'(wdata[2:1]);
				s_nxt.busy = 1'b1;
				s_nxt.nack = 1'b0;
				s_nxt.tick = 16'h0000;
				s_nxt = enter(s_nxt, 3'h0);
			end
		end else if (s_r.st != i2c_port_pkg::M_IDLE) begin
			s_nxt.tick = tk ? 16'h0000 : 16'(s_r.tick + 16'h0001);
			if (tk) begin
				s_nxt.q = 2'(s_r.q + 2'h1);
				case (s_r.st)
					i2c_port_pkg::M_START: begin
						// release, clock high, data falls, clock low
						case (s_r.q)
							2'h0: s_nxt.sda_oe = 1'b0;
							2'h1: s_nxt.scl_oe = 1'b0;
							2'h2: s_nxt.sda_oe = 1'b1;
							default: begin
								s_nxt.scl_oe = 1'b1;
								s_nxt = enter(s_nxt, 3'(s_r.step + 3'h1));
							end
						endcase
					end
					i2c_port_pkg::M_BYTE: begin
						case (s_r.q)
							2'h0: begin
								// data set while clock low, msb first; ack slot released
								s_nxt.sda_oe = (s_r.bitc != i2c_port_pkg::BYTE_BITS) &&
									!s_r.rx && !s_r.sh[7];
							end
							2'h1: s_nxt.scl_oe = 1'b0;
							2'h2: begin
								if (s_r.bitc != i2c_port_pkg::BYTE_BITS) begin
									s_nxt.sh = {s_r.sh[6:0], sda};
								end else if (!s_r.rx && sda) begin
									s_nxt.nack = 1'b1;
								end
							end
							default: begin
								s_nxt.scl_oe = 1'b1;
								s_nxt.bitc = 4'(s_r.bitc + 4'h1);
								if (s_r.bitc == i2c_port_pkg::BYTE_BITS) begin
									if (s_r.rx) begin
										s_nxt.rdat = s_r.sh;
									end
									if (s_r.nack) begin
										// no ack: give up straight to stop
										s_nxt.st = i2c_port_pkg::M_STOP;
										s_nxt.q = 2'h0;
									end else begin
										s_nxt = enter(s_nxt, 3'(s_r.step + 3'h1));
									end
								end
							end
						endcase
					end
					default: begin
						// stop only once the slave has let data go
						case (s_r.q)
							2'h0: s_nxt.sda_oe = 1'b1;
							2'h1: s_nxt.scl_oe = 1'b0;
							2'h2: s_nxt.sda_oe = 1'b0;
							default: begin
								s_nxt.st = i2c_port_pkg::M_IDLE;
								s_nxt.busy = 1'b0;
							end
						endcase
					end
				endcase
			end
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.st <= i2c_port_pkg::M_IDLE;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from state
	assign rdata = s_r.rd_data;
	assign link.scl_m_o = s_r.pin_o;
	assign link.scl_m_oe = s_r.scl_oe;
	assign link.sda_m_o = s_r.pin_o;
	assign link.sda_m_oe = s_r.sda_oe;
endmodule

// ===== rtl/pin_sync.sv
// two-flop synchroniser for pin inputs
module pin_sync #(
	parameter int W = 2 // number of lines
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // sync reset, low active
	input wire logic ce, // clock enable
	input wire logic [W-1:0] d, // asynchronous lines
	output logic [W-1:0] q // synchronised lines
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [W-1:0] meta; // first stage, read by second only
		logic [W-1:0] q; // second stage
	} sync_t;
	sync_t s_r;
	sync_t s_nxt;

	// next state: plain two-stage shift
	always_comb begin
		s_nxt = s_r;
		s_nxt.meta = d;
		s_nxt.q = s_r.meta;
	end

	// lines idle high on an open-drain bus
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '1;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign q = s_r.q;
endmodule

// ===== testbench/i2c_link_monitor.sv
// concurrent checks on the two-wire link between host end and device end
module i2c_link_monitor #(
	parameter logic [6:0] SLV = i2c_port_pkg::SLAVE_ADDR // address the device answers
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // sync reset, low active
	input wire logic scl, // resolved clock line
	input wire logic sda, // resolved data line
	input wire logic sda_m_oe, // host pulls data low
	input wire logic sda_s_oe // device pulls data low
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// helper: where on the wire we are
	logic scl_d; // clock line one cycle ago
	logic sda_d; // data line one cycle ago
	logic [3:0] cnt_r; // clock rises in this byte, 0..8
	logic [1:0] bidx_r; // byte index since start, saturates
	logic [7:0] sh_r; // bits of the byte so far, msb first
	logic rw_r; // direction bit of the slave byte
	logic match_r; // slave byte named this device
	logic seen_r; // inside a frame
	wire start = scl && scl_d && sda_d && !sda; // data falls, clock high
	wire stop = scl && scl_d && !sda_d && sda; // data rises, clock high
	wire rise = scl && !scl_d; // bit sampling point
	wire ninth = rise && cnt_r == 4'h8; // acknowledge slot
	// lines sampled raw, so the device's sync delay only makes it later
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			cnt_r <= 4'h0;
			bidx_r <= 2'h0;
			sh_r <= 8'h00;
			rw_r <= 1'b0;
			match_r <= 1'b0;
			seen_r <= 1'b0;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			if (start) begin
				cnt_r <= 4'h0;
				bidx_r <= 2'h0;
				seen_r <= 1'b1;
			end else if (rise) begin
				cnt_r <= ninth ? 4'h0 : cnt_r + 4'h1;
				if (!ninth)
					sh_r <= {sh_r[6:0], sda};
				if (ninth && bidx_r != 2'h3)
					bidx_r <= bidx_r + 2'h1;
				if (ninth && bidx_r == 2'h0) begin
					rw_r <= sh_r[0];
					match_r <= sh_r[7:1] == SLV;
				end
			end
			if (stop)
				seen_r <= 1'b0;
		end
	end
	// ==========================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_start_by_host: assert property (start |-> sda_m_oe)
		else $error("start not made by host");
	a_quiet_outside: assert property (!seen_r |-> !sda_s_oe)
		else $error("device drove data outside a frame");
	a_stop_by_host: assert property (stop |-> $past(sda_m_oe))
		else $error("stop not made by host");
	a_standby_after_stop: assert property (stop |=> !sda_s_oe [*8])
		else $error("device active after stop");
	a_one_talker: assert property (rise |-> !(sda_m_oe && sda_s_oe))
		else $error("both ends drive data");
	a_slave_ack_match: assert property (ninth && bidx_r == 2'h0
		|-> sda == (sh_r[7:1] != SLV))
		else $error("slave byte acknowledge wrong");
	a_write_ack: assert property (ninth && bidx_r != 2'h0 && match_r && !rw_r
		|-> !sda)
		else $error("written byte not acknowledged");
	a_read_release: assert property (ninth && bidx_r != 2'h0 && rw_r |-> !sda_s_oe)
		else $error("device holds data in read ack slot");
	a_read_host_off: assert property (rise && bidx_r == 2'h1 && rw_r && match_r
		&& cnt_r != 4'h8 |-> !sda_m_oe)
		else $error("host drives during read bits");
	a_dev_steady_high: assert property (scl && scl_d |-> $stable(sda_s_oe))
		else $error("device changed data with clock high");
	c_write_acked: cover property (ninth && bidx_r == 2'h2 && !rw_r && !sda);
	c_read_byte: cover property (ninth && bidx_r == 2'h1 && rw_r);
	c_slave_refused: cover property (ninth && bidx_r == 2'h0 && sda);
endmodule

// ===== testbench/i2c_slave_register_port_tb.sv
// self-checking bench: host end and device end joined, compared with a register model
module i2c_slave_register_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// signals and model state
	localparam logic [6:0] SA = i2c_port_pkg::SLAVE_ADDR; // device address
	logic clk; // 40 mhz
	logic rst_n; // sync reset, low active
	logic [2:0] addr; // command register address
	logic [7:0] wdata; // command write data
	logic wr; // write strobe
	logic rd; // read strobe
	logic [7:0] rdata; // command read data
	logic [87:0] regs_q; // device register contents
	logic [7:0] m [11]; // expected register contents
	int ptr; // expected register pointer
	int miscompares; // mismatches seen
	int samples_checked; // comparisons made
	i2c_link_if link();
	i2c_dev_port i2c_dev_port_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .link(link),
		.regs_q(regs_q));
	// short quarter bit keeps the run brief, still above the sync latency
	i2c_host_port #(.QTR(8)) i2c_host_port_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
	i2c_link_monitor #(.SLV(SA)) i2c_link_monitor_inst (.clk(clk), .rst_n(rst_n),
		.scl(link.scl), .sda(link.sda), .sda_m_oe(link.sda_m_oe), .sda_s_oe(link.sda_s_oe));
	// clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ==========================================================
	// shared tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	// one host operation, then model update and full comparison
	task automatic op(input i2c_port_pkg::op_t code, input logic [6:0] slv,
		input logic [7:0] ra, input logic [7:0] d);
		logic [7:0] st;
		logic [7:0] exp;
		logic hit;
		hit = slv == SA;
		bus_wr(i2c_port_pkg::H_SLV, {1'b0, slv});
		bus_wr(i2c_port_pkg::H_RADR, ra);
		bus_wr(i2c_port_pkg::H_WDAT, d);
		// slave address and write data registers read back before the transfer starts
		bus_rd(i2c_port_pkg::H_SLV, st);
		check(st, {1'b0, slv});
		bus_rd(i2c_port_pkg::H_WDAT, st);
		check(st, d);
		bus_wr(i2c_port_pkg::H_CTRL, {5'h00, code, 1'b1});
		st = 8'h01;
		for (int n = 0; n < 2000 && st[0] !== 1'b0; n++)
			bus_rd(i2c_port_pkg::H_STAT, st);
		if (st[0] !== 1'b0) begin
			// busy never cleared: report it like any mismatch
			check({7'h00, st[0]}, 8'h00);
			conclude();
		end
		check({7'h00, st[1]}, {7'h00, !hit});
		if (hit) begin
			if (code != i2c_port_pkg::OP_CRD)
				ptr = (ra > 8'h0a) ? 0 : int'(ra);
			exp = m[ptr];
			if (code == i2c_port_pkg::OP_WR && !(ptr == 7 && !m[8][7]))
				m[ptr] = d;
			ptr = (ptr == 10) ? 0 : ptr + 1;
			if (code != i2c_port_pkg::OP_WR) begin
				bus_rd(i2c_port_pkg::H_RDAT, st);
				check(st, exp);
			end
		end
		for (int i = 0; i < 11; i++)
			check(regs_q[8*i +: 8], m[i]);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		rst_n = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		ptr = 0;
		miscompares = 0;
		samples_checked = 0;
		for (int i = 0; i < 11; i++)
			m[i] = 8'h00;
		void'($urandom(40));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		// pointer and registers start at zero
		op(i2c_port_pkg::OP_CRD, SA, 8'h05, 8'h00);
		$display("test reset done");
		// feature register locked, unlocked, locked again
		op(i2c_port_pkg::OP_WR, SA, 8'h07, 8'ha5);
		op(i2c_port_pkg::OP_WR, SA, 8'h08, 8'h80);
		op(i2c_port_pkg::OP_WR, SA, 8'h07, 8'h3c);
		op(i2c_port_pkg::OP_WR, SA, 8'h08, 8'h00);
		op(i2c_port_pkg::OP_WR, SA, 8'h07, 8'hc3);
		$display("test gate done");
		// foreign address left unanswered, nothing changes
		op(i2c_port_pkg::OP_WR, SA ^ 7'h01, 8'h02, 8'h77);
		op(i2c_port_pkg::OP_RRD, SA ^ 7'h40, 8'h02, 8'h00);
		$display("test refusal done");
		// random writes kept below the reserved range
		repeat (8)
			op(i2c_port_pkg::OP_WR, SA, 8'($urandom % 9), 8'($urandom));
		// read every place back, one past the end clamps to zero
		for (int i = 0; i < 12; i++)
			op(i2c_port_pkg::OP_RRD, SA, 8'(i), 8'h00);
		$display("test readback done");
		// pointer wraps past the last register, advances after a write
		op(i2c_port_pkg::OP_RRD, SA, 8'h0a, 8'h00);
		op(i2c_port_pkg::OP_CRD, SA, 8'h00, 8'h00);
		op(i2c_port_pkg::OP_WR, SA, 8'h03, 8'($urandom));
		op(i2c_port_pkg::OP_CRD, SA, 8'h00, 8'h00);
		$display("test pointer done");
		conclude();
	end
endmodule
